// ===== shared/dialer_pkg.sv
// Shared constants, types and reset values for the pulse dialer.
package dialer_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and oscillator time base.
    localparam int CLK_HZ      = 100_000_000;  // System clock rate in Hz.
    localparam int OSC_HZ      = 4000;         // Nominal dial oscillator.
    localparam int OSC_DIV_DEF = CLK_HZ / OSC_HZ; // Clocks per tick.

    ////////////////////////////////////////////////////////////////////////
    // Intervals in milliseconds at the nominal oscillator rate, 10 pps.
    localparam int T_DEBOUNCE_MS = 10;    // Key release debounce.
    localparam int T_KEYVALID_MS = 40;    // Key down time for valid entry.
    localparam int T_PDP_MS      = 900;   // Predigital pause.
    localparam int T_IDT_MS      = 900;   // Interdigit time.
    localparam int T_PERIOD_MS   = 100;   // One dial pulse period.
    localparam int T_ONHOOK_MS   = 300;   // On-hook time that arms redial.
    localparam int T_MUTE_MS     = 5;     // Mute hold after last pulse.
    localparam int BRK_PCT_LO    = 60;    // Break share, ratio select low.
    localparam int BRK_PCT_HI    = 66;    // Break share, ratio select high.

    // The same intervals as oscillator ticks.
    localparam logic [11:0] DEBOUNCE_TICKS = 12'(T_DEBOUNCE_MS*OSC_HZ/1000);
    localparam logic [11:0] KEYVALID_TICKS = 12'(T_KEYVALID_MS*OSC_HZ/1000);
    localparam logic [11:0] PDP_TICKS      = 12'(T_PDP_MS*OSC_HZ/1000);
    localparam logic [11:0] IDT_TICKS      = 12'(T_IDT_MS*OSC_HZ/1000);
    localparam logic [11:0] PERIOD_TICKS   = 12'(T_PERIOD_MS*OSC_HZ/1000);
    localparam logic [11:0] ONHOOK_TICKS   = 12'(T_ONHOOK_MS*OSC_HZ/1000);
    localparam logic [11:0] MUTE_TICKS     = 12'(T_MUTE_MS*OSC_HZ/1000);
    localparam logic [11:0] BRK_LO_TICKS   =
        12'(T_PERIOD_MS*OSC_HZ/1000*BRK_PCT_LO/100);
    localparam logic [11:0] BRK_HI_TICKS   =
        12'(T_PERIOD_MS*OSC_HZ/1000*BRK_PCT_HI/100);

    ////////////////////////////////////////////////////////////////////////
    // Keypad and digit memory.
    localparam int ROW_W = 4;                   // Keypad row lines.
    localparam int COL_W = 3;                   // Keypad column lines.
    localparam int PIN_W = ROW_W + COL_W + 3;   // All synchronised pins.
    localparam logic [4:0] MEM_DEPTH   = 5'h11; // Redial digit capacity.
    localparam logic [3:0] KEY_STAR    = 4'hA;  // Row 4, column 1.
    localparam logic [3:0] KEY_ZERO    = 4'hB;  // Row 4, column 2.
    localparam logic [3:0] KEY_HASH    = 4'hC;  // Row 4, column 3.
    localparam logic [3:0] ZERO_PULSES = 4'hA;  // Zero dials ten pulses.

    ////////////////////////////////////////////////////////////////////////
    // Register map and field positions.
    localparam logic [7:0] REG_CTRL   = 8'h00;  // Control, write only.
    localparam logic [7:0] REG_STATUS = 8'h04;  // Status, read only.
    localparam int CTRL_REDIAL_BIT = 0;  // Write 1: replay stored number.
    localparam int CTRL_CLEAR_BIT  = 1;  // Write 1: empty digit memory.
    localparam int STS_HOOK_BIT    = 0;  // Handset off hook.
    localparam int STS_OSC_BIT     = 1;  // Oscillator running.
    localparam int STS_MUTE_BIT    = 2;  // Mute active.
    localparam int STS_BREAK_BIT   = 3;  // Line break active.
    localparam int STS_ARMED_BIT   = 4;  // Redial armed.
    localparam int STS_WR_LSB      = 8;  // Stored digit count, 5 bits.
    localparam int STS_RD_LSB      = 16; // Sent digit count, 5 bits.

    ////////////////////////////////////////////////////////////////////////
    // Outpulsing states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PDP  = 3'b001,
        ST_BRK  = 3'b010,
        ST_MAKE = 3'b011,
        ST_IDT  = 3'b100,
        ST_TAIL = 3'b101
    } dial_state_e;

    // Complete state of the dialer.
    typedef struct packed {
        logic [14:0]       pre;         // Oscillator prescaler.
        logic              base_tick;   // Free time base pulse.
        logic              osc_run;     // Oscillator enabled.
        logic [11:0]       key_cnt;     // Key hold or release counter.
        logic              key_done;    // Key taken, awaiting release.
        logic [6:0]        key_pat;     // Pattern being qualified.
        logic [11:0]       hook_cnt;    // On-hook time counter.
        logic              redial_ok;   // Redial armed after on hook.
        logic [16:0][3:0]  mem;         // Stored pulse counts.
        logic [4:0]        wr_cnt;      // Digits stored.
        logic [4:0]        rd_ptr;      // Digits sent.
        logic [3:0]        pulses_left; // Pulses left in this digit.
        logic [11:0]       tmr;         // Interval down counter.
        dial_state_e       st;          // Outpulsing state.
        logic              pulse_n;     // Line pulse pin level.
        logic              pulse_oe;    // Line pulse pin pulls low.
        logic              mute_n;      // Mute pin level.
        logic              mute_oe;     // Mute pin pulls low.
        logic              pready;      // Bus answer.
        logic              pslverr;     // Bus error answer.
        logic [31:0]       prdata;      // Bus read data.
    } state_s;

    // Value after reset: idle, outputs released, memory empty.
    localparam state_s STATE_RST = '{st: ST_IDLE, pulse_n: 1'b1,
                                     mute_n: 1'b1, default: '0};

endpackage : dialer_pkg

// ===== rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // Synchroniser stages and the filtered result.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s cur;  // Registered state.
    sync_s nxt;  // Next state.

    ////////////////////////////////////////////////////////////////////////
    // A bit follows only once stages two and three agree.
    always_comb begin
        nxt    = cur;
        nxt.s1 = d;
        nxt.s2 = cur.s1;
        nxt.s3 = cur.s2;
        for (int i = 0; i < W; i++) begin
            if (cur.s2[i] == cur.s3[i]) begin
                nxt.q[i] = cur.s3[i];
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign q = cur.q;

endmodule : pin_sync

// ===== rtl/pulse_dialer.sv
// Keypad pulse dialer with redial memory and an APB status port.
`timescale 1ns/1ps

module pulse_dialer #(
    parameter int OSC_DIV = dialer_pkg::OSC_DIV_DEF
) (
    input  wire logic                         MCLK,
    input  wire logic                         RST_B,
    input  wire logic [dialer_pkg::ROW_W-1:0] KEY_ROW,
    input  wire logic [dialer_pkg::COL_W-1:0] KEY_COL,
    input  wire logic                         OFF_HOOK,
    input  wire logic                         DIAL_RATE_SELECT,
    input  wire logic                         MAKE_BREAK_RATIO_SELECT,
    output logic                              LINE_PULSE_OUT_N,
    output logic                              LINE_PULSE_OUT_N_OE,
    output logic                              MUTE_OUT_N,
    output logic                              MUTE_OUT_N_OE,
    input  wire logic                         PSEL,
    input  wire logic                         PENABLE,
    input  wire logic                         PWRITE,
    input  wire logic [7:0]                   PADDR,
    input  wire logic [31:0]                  PWDATA,
    output logic      [31:0]                  PRDATA,
    output logic                              PREADY,
    output logic                              PSLVERR
);
    import dialer_pkg::*;

    logic [1:0]       rst_sync;   // Reset release stages.
    logic             rst_n;      // Released reset for the design.
    logic [PIN_W-1:0] pins;       // Filtered pin levels.
    logic [3:0]       row;        // Active row lines.
    logic [2:0]       col;        // Active column lines.
    logic             off_hook;   // Handset lifted.
    logic             fast;       // Twenty pulses per second.
    logic             ratio;      // Sixty-six percent break.
    logic             key_single; // Exactly one key down.
    logic             key_any;    // Any keypad line active.
    logic             tick;       // Oscillator tick.
    logic             key_accept; // Key qualified this cycle.
    logic [11:0]      brk_full;   // Break ticks at 10 pps.
    logic [11:0]      brk_t;      // Break ticks at selected rate.
    logic [11:0]      per_t;      // Period ticks at selected rate.
    logic [11:0]      make_t;     // Make ticks at selected rate.
    logic [11:0]      pdp_t;      // Pause ticks at selected rate.
    logic [11:0]      idt_t;      // Interdigit ticks at selected rate.
    state_s           cur;        // Registered state.
    state_s           nxt;        // Next state.

    ////////////////////////////////////////////////////////////////////////
    // Reset is released through two flip-flops.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // All pins come from outside the clock domain.
    pin_sync #(.W(PIN_W)) u_pin_sync (
        .clk   (MCLK),
        .rst_n (rst_n),
        .d     ({KEY_ROW, KEY_COL, OFF_HOOK, DIAL_RATE_SELECT,
                 MAKE_BREAK_RATIO_SELECT}),
        .q     (pins)
    );
    assign {row, col, off_hook, fast, ratio} = pins;

    ////////////////////////////////////////////////////////////////////////
    // Key decode and interval selection.
    assign key_single = $onehot(row) & $onehot(col);
    assign key_any    = |{row, col};
    assign tick       = cur.base_tick & cur.osc_run;
    assign brk_full   = ratio ? BRK_HI_TICKS : BRK_LO_TICKS;
    assign brk_t      = fast ? (brk_full >> 1) : brk_full;
    assign per_t      = fast ? (PERIOD_TICKS >> 1) : PERIOD_TICKS;
    assign make_t     = per_t - brk_t;
    assign pdp_t      = fast ? (PDP_TICKS >> 1) : PDP_TICKS;
    assign idt_t      = fast ? (IDT_TICKS >> 1) : IDT_TICKS;

    // Maps one row and one column to key codes 1 to 12.
    function automatic logic [3:0] key_code(input logic [3:0] r,
                                            input logic [2:0] c);
        logic [3:0] ri;
        logic [3:0] ci;
        ri = r[0] ? 4'h0 : r[1] ? 4'h1 : r[2] ? 4'h2 : 4'h3;
        ci = c[0] ? 4'h0 : c[1] ? 4'h1 : 4'h2;
        return (ri * 4'h3) + ci + 4'h1;
    endfunction : key_code

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for keypad, memory, outpulsing and bus.
    always_comb begin
        logic [3:0]  code;
        logic [3:0]  digit;
        logic [31:0] rd;
        code  = key_code(row, col);
        digit = (code == KEY_ZERO) ? ZERO_PULSES : code;
        rd    = '0;
        key_accept    = 1'b0;
        nxt           = cur;
        nxt.base_tick = 1'b0;
        nxt.pready    = 1'b0;
        nxt.pslverr   = 1'b0;
        // Free-running time base; ticks count only while running.
        if (cur.pre == 15'(OSC_DIV - 1)) begin
            nxt.pre       = '0;
            nxt.base_tick = 1'b1;
        end else begin
            nxt.pre = cur.pre + 15'h1;
        end
        // Oscillator runs off hook while a key or dialing is active.
        nxt.osc_run = off_hook & (key_single | cur.key_done |
                                  (cur.st != ST_IDLE));
        // On-hook timer arms redial after the minimum time.
        if (off_hook) begin
            nxt.hook_cnt = '0;
        end else if (cur.hook_cnt == ONHOOK_TICKS) begin
            nxt.redial_ok = 1'b1;
        end else if (cur.base_tick) begin
            nxt.hook_cnt = cur.hook_cnt + 12'h1;
        end
        // Keypad qualification; nothing is seen on hook.
        if (!off_hook) begin
            nxt.key_cnt  = '0;
            nxt.key_done = 1'b0;
        end else if (cur.key_done) begin
            // Wait for a clean release before the next key.
            if (key_any) begin
                nxt.key_cnt = '0;
            end else if (tick) begin
                if (cur.key_cnt == DEBOUNCE_TICKS - 12'h1) begin
                    nxt.key_done = 1'b0;
                    nxt.key_cnt  = '0;
                end else begin
                    nxt.key_cnt = cur.key_cnt + 12'h1;
                end
            end
        end else if (key_single) begin
            // A changed pattern restarts the hold time.
            if ({row, col} != cur.key_pat) begin
                nxt.key_pat = {row, col};
                nxt.key_cnt = '0;
            end else if (tick) begin
                if (cur.key_cnt == KEYVALID_TICKS - 12'h1) begin
                    key_accept   = 1'b1;
                    nxt.key_done = 1'b1;
                    nxt.key_cnt  = '0;
                end else begin
                    nxt.key_cnt = cur.key_cnt + 12'h1;
                end
            end
        end else begin
            nxt.key_cnt = '0;
        end
        // Accepted key: redial request or a new digit.
        if (key_accept) begin
            nxt.redial_ok = 1'b0;
            if (code == KEY_STAR || code == KEY_HASH) begin
                if (cur.redial_ok && cur.st == ST_IDLE) begin
                    nxt.rd_ptr = '0;
                end
            end else if (cur.redial_ok) begin
                // First digit of a new call replaces the old number.
                nxt.mem[0] = digit;
                nxt.wr_cnt = 5'h1;
                nxt.rd_ptr = '0;
            end else if (cur.wr_cnt < MEM_DEPTH) begin
                nxt.mem[cur.wr_cnt] = digit;
                nxt.wr_cnt = cur.wr_cnt + 5'h1;
            end
        end
        // Bus setup cycle: decode and prepare the answer.
        if (PSEL && !PENABLE && !cur.pready) begin
            nxt.pready = 1'b1;
            rd[STS_HOOK_BIT]          = off_hook;
            rd[STS_OSC_BIT]           = cur.osc_run;
            rd[STS_MUTE_BIT]          = cur.mute_oe;
            rd[STS_BREAK_BIT]         = cur.pulse_oe;
            rd[STS_ARMED_BIT]         = cur.redial_ok;
            rd[STS_WR_LSB +: 5]       = cur.wr_cnt;
            rd[STS_RD_LSB +: 5]       = cur.rd_ptr;
            nxt.prdata  = (PADDR == REG_STATUS) ? rd : '0;
            nxt.pslverr = (PADDR != REG_STATUS) && (PADDR != REG_CTRL);
        end
        // Control write takes effect at the completing edge.
        if (PSEL && PENABLE && PWRITE && cur.pready &&
            PADDR == REG_CTRL && cur.st == ST_IDLE) begin
            if (PWDATA[CTRL_REDIAL_BIT] && off_hook) begin
                nxt.rd_ptr = '0;
            end
            if (PWDATA[CTRL_CLEAR_BIT]) begin
                nxt.wr_cnt = '0;
                nxt.rd_ptr = '0;
            end
        end
        // Outpulsing sequence; hanging up aborts it.
        if (!off_hook) begin
            nxt.st = ST_IDLE;
        end else begin
            unique case (cur.st)
                ST_IDLE: begin
                    if (nxt.rd_ptr < nxt.wr_cnt) begin
                        nxt.st  = ST_PDP;
                        nxt.tmr = pdp_t - 12'h1;
                    end
                end
                ST_PDP, ST_IDT: begin
                    if (tick && cur.tmr == '0) begin
                        nxt.pulses_left = cur.mem[cur.rd_ptr];
                        nxt.rd_ptr      = cur.rd_ptr + 5'h1;
                        nxt.st          = ST_BRK;
                        nxt.tmr         = brk_t - 12'h1;
                    end else if (tick) begin
                        nxt.tmr = cur.tmr - 12'h1;
                    end
                end
                ST_BRK: begin
                    if (tick && cur.tmr == '0) begin
                        nxt.st  = ST_MAKE;
                        nxt.tmr = make_t - 12'h1;
                    end else if (tick) begin
                        nxt.tmr = cur.tmr - 12'h1;
                    end
                end
                ST_MAKE: begin
                    if (tick && cur.tmr == '0) begin
                        if (cur.pulses_left > 4'h1) begin
                            nxt.pulses_left = cur.pulses_left - 4'h1;
                            nxt.st  = ST_BRK;
                            nxt.tmr = brk_t - 12'h1;
                        end else if (cur.rd_ptr < cur.wr_cnt) begin
                            nxt.st  = ST_IDT;
                            nxt.tmr = idt_t - 12'h1;
                        end else begin
                            nxt.st  = ST_TAIL;
                            nxt.tmr = MUTE_TICKS - 12'h1;
                        end
                    end else if (tick) begin
                        nxt.tmr = cur.tmr - 12'h1;
                    end
                end
                ST_TAIL: begin
                    if (cur.rd_ptr < cur.wr_cnt) begin
                        nxt.st  = ST_IDT;
                        nxt.tmr = idt_t - 12'h1;
                    end else if (tick && cur.tmr == '0) begin
                        nxt.st = ST_IDLE;
                    end else if (tick) begin
                        nxt.tmr = cur.tmr - 12'h1;
                    end
                end
                default: begin
                    nxt.st = ST_IDLE;
                end
            endcase
        end
        // Open-drain pins pull low during break and while muting.
        nxt.pulse_oe = (nxt.st == ST_BRK);
        nxt.pulse_n  = (nxt.st != ST_BRK);
        nxt.mute_oe  = (nxt.st != ST_IDLE);
        nxt.mute_n   = (nxt.st == ST_IDLE);
    end

    // State register.
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            cur <= STATE_RST;
        end else begin
            cur <= nxt;
        end
    end

    assign LINE_PULSE_OUT_N    = cur.pulse_n;
    assign LINE_PULSE_OUT_N_OE = cur.pulse_oe;
    assign MUTE_OUT_N          = cur.mute_n;
    assign MUTE_OUT_N_OE       = cur.mute_oe;
    assign PRDATA              = cur.prdata;
    assign PREADY              = cur.pready;
    assign PSLVERR             = cur.pslverr;

    ////////////////////////////////////////////////////////////////////////
    // Checks. Helper counts oscillator ticks spent in each break.
    logic [11:0] brk_ticks_reg;
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            brk_ticks_reg <= '0;
        end else if (cur.st != ST_BRK) begin
            brk_ticks_reg <= '0;
        end else if (tick) begin
            brk_ticks_reg <= brk_ticks_reg + 12'h1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n);

    AST_ONHOOK_IDLE: assert property (!off_hook |=> cur.st == ST_IDLE)
        else $error("Dialing continued on hook.");
    AST_OSC_GATED: assert property (!off_hook |=> !cur.osc_run)
        else $error("Oscillator ran on hook.");
    AST_PULSE_PIN: assert property (
        (cur.st == ST_BRK) == !LINE_PULSE_OUT_N)
        else $error("Pulse pin disagrees with break state.");
    AST_MUTE_SPAN: assert property (
        $fell(MUTE_OUT_N) |-> cur.st == ST_PDP)
        else $error("Mute began outside the pause.");
    AST_MEM_LIMIT: assert property (cur.wr_cnt <= MEM_DEPTH)
        else $error("Digit memory overfilled.");
    AST_ORDER: assert property (cur.rd_ptr <= cur.wr_cnt)
        else $error("Sent more digits than stored.");
    AST_BREAK_LEN: assert property (
        (cur.st == ST_BRK && nxt.st == ST_MAKE)
        |-> brk_ticks_reg + 12'h1 == brk_t)
        else $error("Break length wrong.");
    AST_DIGIT_LOAD: assert property (
        (cur.st == ST_PDP && nxt.st == ST_BRK)
        |=> cur.pulses_left inside {[4'h1:4'hA]})
        else $error("Digit pulse count out of range.");
    AST_SINGLE_KEY: assert property (
        key_accept |-> key_single && off_hook)
        else $error("Key taken without a single key.");
    AST_REDIAL_ARM: assert property (
        (key_accept && cur.redial_ok) |=> !cur.redial_ok)
        else $error("Redial stayed armed after a key.");

    COV_DIAL: cover property (cur.st == ST_TAIL ##1 cur.st == ST_IDLE);
    COV_FULL: cover property (cur.wr_cnt == MEM_DEPTH);
    COV_REDIAL: cover property (key_accept && cur.redial_ok &&
                                (key_code(row, col) == KEY_STAR));
    COV_FAST: cover property (fast && cur.st == ST_BRK);

endmodule : pulse_dialer

// ===== test/keypad_line_model.sv
// Keypad matrix and line switch model for the pulse dialer.
`timescale 1ns/1ps
module keypad_line_model (
    input  wire logic       clk,
    input  wire logic [3:0] key,      // Key code, 1 to 9, A to C.
    input  wire logic       press,    // High while the key is held.
    output logic      [3:0] row,      // Row lines, high when joined.
    output logic      [2:0] col,      // Column lines, high when joined.
    input  wire logic       pulse_oe, // Dialer sinks the line pin.
    input  wire logic       pulse_n,  // Dialer pin level while driving.
    output int              n_brk,    // Breaks seen on the line.
    output int              brk_len   // Cycles of the last break.
);
    int cur      = 0;  // Cycles of the break in progress.
    int brk_cnt  = 0;  // Breaks seen so far.
    int brk_last = 0;  // Length of the last break.
    assign n_brk   = brk_cnt;
    assign brk_len = brk_last;
    // Pull-up holds the line high unless the dialer sinks it.
    wire line = !(pulse_oe && !pulse_n);
    // One key joins one row and one column; idle lines sit low.
    assign row = press ? 4'(1 << ((key - 4'h1) / 3)) : 4'h0;
    assign col = press ? 3'(1 << ((key - 4'h1) % 3)) : 3'h0;
    // Count breaks and time each one in clock cycles.
    always @(posedge clk) begin
        if (!line) cur <= cur + 1;
        else if (cur != 0) begin
            brk_cnt <= brk_cnt + 1;
            brk_last <= cur;
            cur <= 0;
        end
    end
endmodule : keypad_line_model

// ===== test/pulse_dialer_tb.sv
// Self-checking bench for the pulse dialer.
`timescale 1ns/1ps
module pulse_dialer_tb;
    import dialer_pkg::*;
    localparam int DIV = 5;  // Short oscillator tick for simulation.
    logic MCLK = 0, RST_B = 0, HOOK = 0, RATE = 0, RATIO = 0, err;
    logic [3:0] KEY = KEY_ZERO;  // Key that the keypad model presses.
    logic PSEL = 0, PENABLE = 0, PWRITE = 0, press = 0, MUTE, PREADY;
    logic [7:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic [3:0] KEY_ROW;
    logic [2:0] KEY_COL;
    logic PSLVERR, LPO_OE, LPO, MUTE_OE;
    int n_errors = 0, n_tests = 0, n_brk, brk_len;
    pulse_dialer #(.OSC_DIV(DIV)) dut (.MCLK(MCLK), .RST_B(RST_B),
        .KEY_ROW(KEY_ROW), .KEY_COL(KEY_COL), .OFF_HOOK(HOOK),
        .DIAL_RATE_SELECT(RATE), .MAKE_BREAK_RATIO_SELECT(RATIO),
        .LINE_PULSE_OUT_N(LPO), .LINE_PULSE_OUT_N_OE(LPO_OE),
        .MUTE_OUT_N(MUTE), .MUTE_OUT_N_OE(MUTE_OE), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR));
    keypad_line_model far (.clk(MCLK), .key(KEY), .press(press),
        .row(KEY_ROW), .col(KEY_COL), .pulse_oe(LPO_OE), .pulse_n(LPO),
        .n_brk(n_brk), .brk_len(brk_len));
    // Compare and count; report a mismatch at once.
    task automatic check(input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; request held until PREADY is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask : apb
    // Wait for mute release; a run-out counts as a mismatch.
    task automatic wait_mute();
        for (int i = 0; i < 60000 && MUTE !== 1'b1; i++) @(posedge MCLK);
        check(32'(MUTE), 32'h1);
    endtask : wait_mute
    // Print the counts and the verdict, then stop.
    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial forever #5 MCLK = ~MCLK;
    // Watchdog well past the expected 70000 cycles.
    initial begin
        #900_000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge MCLK);
        RST_B <= 1;
        repeat (4) @(posedge MCLK);
        apb(0, REG_STATUS, 0);
        check(rd, 32'h0);
        apb(0, 8'h08, 0);
        check(32'(err), 32'h1);
        $display("test reset done");
        press <= 1;
        repeat (2000) @(posedge MCLK);
        press <= 0;
        apb(0, REG_STATUS, 0);
        check(rd, 32'h0);
        $display("test on-hook done");
        HOOK <= 1;
        RATE <= 1;
        RATIO <= 1;
        repeat (1000) @(posedge MCLK);
        press <= 1;
        repeat (2000) @(posedge MCLK);
        check(32'(MUTE), 32'h0);
        check(32'(MUTE_OE), 32'h1);
        press <= 0;
        wait_mute();
        check(32'(MUTE_OE), 32'h0);
        check(32'(LPO_OE), 32'h0);
        check(n_brk, 32'(ZERO_PULSES));
        check(brk_len, 32'(BRK_HI_TICKS / 2 * DIV));
        apb(0, REG_STATUS, 0);
        check(32'(rd[20:8]), 32'h0101);
        $display("test dial done");
        HOOK <= 0;
        RATE <= 0;
        RATIO <= 0;
        KEY <= KEY_STAR;
        repeat (6500) @(posedge MCLK);
        apb(0, REG_STATUS, 0);
        check(32'(rd[STS_ARMED_BIT]), 32'h1);
        HOOK <= 1;
        repeat (1000) @(posedge MCLK);
        press <= 1;
        repeat (2000) @(posedge MCLK);
        press <= 0;
        wait_mute();
        check(n_brk, 32'(2 * ZERO_PULSES));
        check(brk_len, 32'(BRK_LO_TICKS * DIV));
        apb(1, REG_CTRL, 32'h2);
        apb(0, REG_STATUS, 0);
        check(32'(rd[20:8]), 32'h0);
        $display("test redial done");
        summarize();
    end
endmodule : pulse_dialer_tb
